// file: src/cmd_handler_defs.vh
// Constants for the custom command handler of a vicinity transponder.
// Assumes a 125 MHz core clock and an upstream frame decoder.
`ifndef CMD_HANDLER_DEFS_VH
`define CMD_HANDLER_DEFS_VH

`define CLK_MHZ          125
`define CMD_KILL         8'hb9
`define CMD_PRIV_ON      8'hba
`define CMD_PRIV_OFF     8'hbb
`define CMD_RAND_ON      8'hbe
`define CMD_RAND_OFF     8'hbf
`define CMD_FAST_READ    8'hc3
`define CMD_LOGIN        8'he4
`define ERR_NOT_ALLOWED  8'h0f
`define ERR_BAD_PASSWORD 8'h0f
`define NVM_SEL_KILL     2'h0
`define NVM_SEL_PRIV     2'h1
`define NVM_SEL_RAND     2'h2
`define UID_W            64
`define UID_RAND_W       40
`define LFSR_SEED        40'h5a5a_c3c3_01
`define LFSR_TAPS        40'h80_0000_0015
`define CNT_W            24
`define CNT_ONE          24'h00_0001
`define CNT_ZERO         24'h00_0000

`endif

// file: src/uid_randomizer.v
// Random low part of the identifier, one snapshot per power-up.
// Assumes entropy_bit is already synchronised to sys_clk.
`timescale 1ns/1ns
`include "cmd_handler_defs.vh"

module uid_randomizer
(
  input  wire                   sys_clk,
  input  wire                   reset,
  input  wire                   entropy_bit,
  input  wire                   capture,
  output reg  [`UID_RAND_W-1:0] rand_part_ff
);

  reg  [`UID_RAND_W-1:0] lfsr_ff;
  wire [`UID_RAND_W-1:0] nxt_lfsr;
  wire                   feedback;

  assign feedback = ^(lfsr_ff & `LFSR_TAPS) ^ entropy_bit;
  assign nxt_lfsr = {lfsr_ff[`UID_RAND_W-2:0], feedback};

  // Free running; arrival time of first request adds entropy
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      lfsr_ff      <= `LFSR_SEED;
      rand_part_ff <= `LFSR_SEED;
    end
    else
    begin
      lfsr_ff <= nxt_lfsr;
      if (capture)
        rand_part_ff <= lfsr_ff;
    end
  end

endmodule

// file: src/secure_custom_command_handler.v
// Custom command interpreter: kill, privacy, random identifier,
// fast multi-block read and login.
// Assumes a frame decoder delivers checked requests as one-cycle
// pulses and an NVM controller performs the requested bit writes.
`timescale 1ns/1ns
`include "cmd_handler_defs.vh"

module secure_custom_command_handler
#(
  parameter T_KILL_US      = 20000,
  parameter T_PRIV_ON_US   = 20000,
  parameter T_PRIV_OFF_US  = 20000,
  parameter T_RAND_ON_US   = 20000,
  parameter T_RAND_OFF_US  = 20000
)
(
  input  wire                   sys_clk,
  input  wire                   reset,
  input  wire                   req_valid,
  input  wire [7:0]             req_cmd,
  input  wire                   req_crc_ok,
  input  wire                   req_option,
  input  wire                   req_addressed,
  input  wire [`UID_W-1:0]      req_uid,
  input  wire [31:0]            req_password,
  input  wire                   selected_state,
  input  wire                   reader_eof,
  input  wire [31:0]            stored_password,
  input  wire [`UID_W-1:0]      fixed_uid,
  input  wire                   nv_kill,
  input  wire                   nv_privacy,
  input  wire                   nv_random,
  input  wire                   entropy_pin,
  output reg                    rsp_valid_ff,
  output reg                    rsp_error_ff,
  output reg  [7:0]             rsp_code_ff,
  output reg                    rsp_fast_read_ff,
  output reg                    nvm_wr_ff,
  output reg  [1:0]             nvm_sel_ff,
  output reg                    nvm_val_ff,
  output reg                    busy_ff,
  output reg                    dead_ff,
  output reg                    secure_ff,
  output reg                    privacy_ff,
  output reg                    random_en_ff,
  output reg  [`UID_W-1:0]      active_uid_ff,
  output reg  [`UID_W-1:0]      sysinfo_uid_ff
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_PROG = 2'h1;
  localparam [1:0] ST_EOF  = 2'h2;

  // Products at full width, the counter keeps the low bits
  localparam [31:0] KILL_PROD     = T_KILL_US * `CLK_MHZ;
  localparam [31:0] PRIV_ON_PROD  = T_PRIV_ON_US * `CLK_MHZ;
  localparam [31:0] PRIV_OFF_PROD = T_PRIV_OFF_US * `CLK_MHZ;
  localparam [31:0] RAND_ON_PROD  = T_RAND_ON_US * `CLK_MHZ;
  localparam [31:0] RAND_OFF_PROD = T_RAND_OFF_US * `CLK_MHZ;

  localparam [`CNT_W-1:0] KILL_CYC      = KILL_PROD[`CNT_W-1:0];
  localparam [`CNT_W-1:0] PRIV_ON_CYC   = PRIV_ON_PROD[`CNT_W-1:0];
  localparam [`CNT_W-1:0] PRIV_OFF_CYC  = PRIV_OFF_PROD[`CNT_W-1:0];
  localparam [`CNT_W-1:0] RAND_ON_CYC   = RAND_ON_PROD[`CNT_W-1:0];
  localparam [`CNT_W-1:0] RAND_OFF_CYC  = RAND_OFF_PROD[`CNT_W-1:0];

  // Commands that program a non-volatile bit
  function is_write_cmd;
    input [7:0] cmd;
    begin
      is_write_cmd = (cmd == `CMD_KILL) || (cmd == `CMD_PRIV_ON) ||
                     (cmd == `CMD_PRIV_OFF) || (cmd == `CMD_RAND_ON) ||
                     (cmd == `CMD_RAND_OFF);
    end
  endfunction

  // Write commands that also need addressed or selected state
  function needs_address;
    input [7:0] cmd;
    begin
      needs_address = (cmd == `CMD_KILL) || (cmd == `CMD_RAND_ON) ||
                      (cmd == `CMD_RAND_OFF);
    end
  endfunction

  // Programming time of each write command
  function [`CNT_W-1:0] prog_cycles;
    input [7:0] cmd;
    begin
      case (cmd)
        `CMD_KILL:     prog_cycles = KILL_CYC;
        `CMD_PRIV_ON:  prog_cycles = PRIV_ON_CYC;
        `CMD_PRIV_OFF: prog_cycles = PRIV_OFF_CYC;
        `CMD_RAND_ON:  prog_cycles = RAND_ON_CYC;
        default:       prog_cycles = RAND_OFF_CYC;
      endcase
    end
  endfunction

  reg  [1:0]              state_ff;
  reg  [1:0]              nxt_state;
  reg  [`CNT_W-1:0]       cnt_ff;
  reg  [`CNT_W-1:0]       nxt_cnt;
  reg                     load_ff;
  reg                     first_req_ff;
  reg                     entropy_meta_ff;
  reg                     entropy_ff;
  wire [`UID_RAND_W-1:0]  rand_part;
  wire [`UID_W-1:0]       rand_uid;
  wire                    uid_match;
  wire                    accept;
  wire                    addr_ok;
  wire                    pw_match;
  wire                    capture;

  // Next values of the registered outputs
  reg                     nxt_rsp_valid;
  reg                     nxt_rsp_error;
  reg  [7:0]              nxt_rsp_code;
  reg                     nxt_rsp_fast;
  reg                     nxt_nvm_wr;
  reg  [1:0]              nxt_nvm_sel;
  reg                     nxt_nvm_val;
  reg                     nxt_secure;
  reg                     nxt_privacy;
  reg                     nxt_random;

  // Entropy pin is asynchronous
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      entropy_meta_ff <= 1'b0;
      entropy_ff      <= 1'b0;
    end
    else
    begin
      entropy_meta_ff <= entropy_pin;
      entropy_ff      <= entropy_meta_ff;
    end
  end

  // First request after reset freezes the random part
  assign capture = first_req_ff & req_valid;

  uid_randomizer u_rand
  (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .entropy_bit  (entropy_ff),
    .capture      (capture),
    .rand_part_ff (rand_part)
  );

  // Maker prefix stays fixed, low part is random
  assign rand_uid = {fixed_uid[`UID_W-1:`UID_RAND_W], rand_part};

  // Addressed requests match the identifier presented to readers
  assign uid_match = req_uid == active_uid_ff;
  assign addr_ok   = (req_addressed & uid_match) | selected_state;
  assign pw_match  = req_password == stored_password;

  // Dead device and undecodable frames are dropped; state untouched
  assign accept = req_valid & req_crc_ok & ~dead_ff & ~load_ff &
                  (state_ff == ST_IDLE) &
                  (~req_addressed | uid_match);

  always @*
  begin
    nxt_state     = state_ff;
    nxt_cnt       = cnt_ff;
    nxt_rsp_valid = 1'b0;
    nxt_rsp_error = 1'b0;
    nxt_rsp_code  = rsp_code_ff;
    nxt_rsp_fast  = 1'b0;
    nxt_nvm_wr    = 1'b0;
    nxt_nvm_sel   = nvm_sel_ff;
    nxt_nvm_val   = nvm_val_ff;
    nxt_secure    = secure_ff;
    nxt_privacy   = privacy_ff;
    nxt_random    = random_en_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (accept && is_write_cmd(req_cmd))
        begin
          if (!secure_ff ||
              (needs_address(req_cmd) && !addr_ok))
          begin
            // Refused: answer flags plus code, nothing programmed
            nxt_rsp_valid = 1'b1;
            nxt_rsp_error = 1'b1;
            nxt_rsp_code  = `ERR_NOT_ALLOWED;
          end
          else
          begin
            nxt_nvm_wr = 1'b1;
            nxt_cnt    = prog_cycles(req_cmd);
            nxt_state  = req_option ? ST_EOF : ST_PROG;
            case (req_cmd)
              `CMD_KILL:
              begin
                nxt_nvm_sel = `NVM_SEL_KILL;
                nxt_nvm_val = 1'b1;
              end
              `CMD_PRIV_ON:
              begin
                nxt_nvm_sel = `NVM_SEL_PRIV;
                nxt_nvm_val = 1'b1;
                nxt_privacy = 1'b1;
              end
              `CMD_PRIV_OFF:
              begin
                nxt_nvm_sel = `NVM_SEL_PRIV;
                nxt_nvm_val = 1'b0;
                nxt_privacy = 1'b0;
              end
              `CMD_RAND_ON:
              begin
                nxt_nvm_sel = `NVM_SEL_RAND;
                nxt_nvm_val = 1'b1;
                nxt_random  = 1'b1;
              end
              default:
              begin
                nxt_nvm_sel = `NVM_SEL_RAND;
                nxt_nvm_val = 1'b0;
                nxt_random  = 1'b0;
              end
            endcase
          end
        end
        else if (accept && req_cmd == `CMD_LOGIN)
        begin
          nxt_rsp_valid = 1'b1;
          if (pw_match)
            nxt_secure = 1'b1;
          else
          begin
            // Mismatch reports error, secure mode kept as is
            nxt_rsp_error = 1'b1;
            nxt_rsp_code  = `ERR_BAD_PASSWORD;
          end
        end
        else if (accept && req_cmd == `CMD_FAST_READ)
        begin
          // Read path serves the blocks at the fast return rate
          nxt_rsp_valid = 1'b1;
          nxt_rsp_fast  = 1'b1;
        end
      end
      ST_PROG:
      begin
        if (cnt_ff <= `CNT_ONE)
        begin
          nxt_cnt       = `CNT_ZERO;
          nxt_rsp_valid = 1'b1;
          nxt_state     = ST_IDLE;
        end
        else
          nxt_cnt = cnt_ff - `CNT_ONE;
      end
      ST_EOF:
      begin
        // Reader is trusted to have waited the programming time
        if (reader_eof)
        begin
          nxt_rsp_valid = 1'b1;
          nxt_state     = ST_IDLE;
        end
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_ff         <= ST_IDLE;
      cnt_ff           <= `CNT_ZERO;
      load_ff          <= 1'b1;
      first_req_ff     <= 1'b1;
      rsp_valid_ff     <= 1'b0;
      rsp_error_ff     <= 1'b0;
      rsp_code_ff      <= 8'h00;
      rsp_fast_read_ff <= 1'b0;
      nvm_wr_ff        <= 1'b0;
      nvm_sel_ff       <= `NVM_SEL_KILL;
      nvm_val_ff       <= 1'b0;
      busy_ff          <= 1'b0;
      dead_ff          <= 1'b0;
      secure_ff        <= 1'b0;
      privacy_ff       <= 1'b0;
      random_en_ff     <= 1'b0;
    end
    else if (load_ff)
    begin
      // Non-volatile bits sampled once after power-on reset
      load_ff      <= 1'b0;
      dead_ff      <= nv_kill;
      privacy_ff   <= nv_privacy;
      random_en_ff <= nv_random;
    end
    else
    begin
      if (req_valid)
        first_req_ff <= 1'b0;
      state_ff         <= nxt_state;
      cnt_ff           <= nxt_cnt;
      rsp_valid_ff     <= nxt_rsp_valid;
      rsp_error_ff     <= nxt_rsp_error;
      rsp_code_ff      <= nxt_rsp_code;
      rsp_fast_read_ff <= nxt_rsp_fast;
      nvm_wr_ff        <= nxt_nvm_wr;
      nvm_sel_ff       <= nxt_nvm_sel;
      nvm_val_ff       <= nxt_nvm_val;
      busy_ff          <= nxt_state != ST_IDLE;
      secure_ff        <= nxt_secure;
      privacy_ff       <= nxt_privacy;
      random_en_ff     <= nxt_random;
    end
  end

  // Identifier views follow the feature, the sysinfo view also secure mode
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      active_uid_ff  <= {`UID_W{1'b0}};
      sysinfo_uid_ff <= {`UID_W{1'b0}};
    end
    else
    begin
      active_uid_ff  <= random_en_ff ? rand_uid : fixed_uid;
      sysinfo_uid_ff <= (random_en_ff && !secure_ff) ?
                        rand_uid : fixed_uid;
    end
  end

endmodule

// file: dv/handler_props.sv
// Port checker for the custom command handler.
// Assumes all programming times equal T_KILL_US and bind below.
`timescale 1ns/1ns
`include "cmd_handler_defs.vh"
module handler_props
#(
  parameter T_KILL_US = 1
)
(
  input wire              sys_clk,
  input wire              reset,
  input wire              req_valid,
  input wire [7:0]        req_cmd,
  input wire              req_crc_ok,
  input wire              req_addressed,
  input wire [31:0]       req_password,
  input wire [31:0]       stored_password,
  input wire [`UID_W-1:0] fixed_uid,
  input wire              rsp_valid_ff,
  input wire              rsp_error_ff,
  input wire [7:0]        rsp_code_ff,
  input wire              rsp_fast_read_ff,
  input wire              nvm_wr_ff,
  input wire              busy_ff,
  input wire              dead_ff,
  input wire              secure_ff,
  input wire              random_en_ff,
  input wire [`UID_W-1:0] sysinfo_uid_ff
);
  localparam PROG = T_KILL_US * `CLK_MHZ;
  reg  [23:0] busy_cnt_ff;
  reg  [1:0]  age_ff;
  wire        take;
  wire        pw_ok;
  assign take = req_valid && req_crc_ok && !busy_ff && !dead_ff &&
                !req_addressed && age_ff != 2'h0;
  assign pw_ok = req_password == stored_password;
  always @(posedge sys_clk)
  begin
    busy_cnt_ff <= busy_ff ? busy_cnt_ff + 24'h1 : 24'h0;
    age_ff <= reset ? 2'h0 : (age_ff == 2'h3 ? 2'h3 : age_ff + 2'h1);
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  AST_ERR_CODE: assert property (
    rsp_valid_ff && rsp_error_ff |-> rsp_code_ff == `ERR_NOT_ALLOWED)
    else $error("error code wrong");
  AST_FAST_OK: assert property (
    rsp_fast_read_ff |-> rsp_valid_ff && !rsp_error_ff)
    else $error("fast rate on bad answer");
  AST_FAST_ANS: assert property (
    take && req_cmd == `CMD_FAST_READ |=> rsp_valid_ff && rsp_fast_read_ff)
    else $error("fast read not served");
  AST_KILL_REJ: assert property (
    take && req_cmd == `CMD_KILL && !secure_ff |=> rsp_valid_ff &&
    rsp_error_ff) else $error("kill outside secure");
  AST_WR_SECURE: assert property (
    nvm_wr_ff |-> secure_ff) else $error("write outside secure");
  AST_LOGIN_OK: assert property (
    take && req_cmd == `CMD_LOGIN && pw_ok |=> rsp_valid_ff &&
    !rsp_error_ff && secure_ff) else $error("login refused");
  AST_LOGIN_BAD: assert property (
    take && req_cmd == `CMD_LOGIN && !pw_ok |=> rsp_valid_ff &&
    rsp_error_ff) else $error("bad password taken");
  AST_SEC_KEEP: assert property (
    secure_ff |=> secure_ff) else $error("secure mode lost");
  AST_PROG_MIN: assert property (
    $fell(busy_ff) && age_ff == 2'h3 |-> rsp_valid_ff &&
    busy_cnt_ff >= PROG) else $error("write answered early");
  AST_SYSINFO: assert property (
    secure_ff && $past(secure_ff) && random_en_ff && $past(random_en_ff)
    |-> sysinfo_uid_ff == fixed_uid) else $error("sysinfo uid wrong");
  cover property (take && req_cmd == `CMD_LOGIN && pw_ok);
  cover property ($fell(busy_ff) && age_ff == 2'h3);
  cover property (rsp_fast_read_ff);
endmodule
bind secure_custom_command_handler handler_props
  #(.T_KILL_US(T_KILL_US)) i_props (.sys_clk(sys_clk), .reset(reset),
  .req_valid(req_valid), .req_cmd(req_cmd), .req_crc_ok(req_crc_ok),
  .req_addressed(req_addressed), .req_password(req_password),
  .stored_password(stored_password), .fixed_uid(fixed_uid),
  .rsp_valid_ff(rsp_valid_ff), .rsp_error_ff(rsp_error_ff),
  .rsp_code_ff(rsp_code_ff), .rsp_fast_read_ff(rsp_fast_read_ff),
  .nvm_wr_ff(nvm_wr_ff), .busy_ff(busy_ff), .dead_ff(dead_ff),
  .secure_ff(secure_ff), .random_en_ff(random_en_ff),
  .sysinfo_uid_ff(sysinfo_uid_ff));

// file: dv/reader_model.sv
// Reader side: lone end-of-frame for an option-flag write.
// Assumes the bench holds opt_pend high until the answer.
`timescale 1ns/1ns
module reader_model
(
  input  wire       sys_clk,
  input  wire       opt_pend,
  input  wire [9:0] wait_cyc,
  output reg        eof_ff
);
  reg [9:0] cnt_ff;
  initial eof_ff = 1'h0;
  initial cnt_ff = 10'h0;
  always @(posedge sys_clk)
  begin
    cnt_ff <= #1 opt_pend ? cnt_ff + 10'h1 : 10'h0;
    eof_ff <= #1 opt_pend && cnt_ff == wait_cyc;
  end
endmodule

// file: dv/secure_custom_command_handler_tb.sv
// Self-checking bench for the custom command handler.
// Assumes 1 us programming times and the reader model for EOF.
`timescale 1ns/1ns
`include "cmd_handler_defs.vh"
module secure_custom_command_handler_tb;
  reg         sys_clk, reset, req_valid, req_crc_ok, req_option;
  reg         selected_state, nv_kill, entropy_pin, opt_pend;
  reg         req_addressed, nv_privacy, nv_random;
  reg  [7:0]  req_cmd;
  reg  [9:0]  wait_cyc;
  reg  [31:0] req_password, stored_password;
  reg  [31:0] lfsr_ff = 32'hd821;
  reg  [63:0] fixed_uid, req_uid, first_uid;
  reg  [7:0]  nvm_cnt = 8'h0;
  reg  [2:0]  nvm_last = 3'h0;
  reg  [1:0]  exp_q[$];
  wire        reader_eof, rsp_valid_ff, rsp_error_ff, rsp_fast_read_ff;
  wire        busy_ff, dead_ff, secure_ff, privacy_ff, random_en_ff;
  wire [7:0]  rsp_code_ff;
  wire        nvm_wr_ff, nvm_val_ff;
  wire [1:0]  nvm_sel_ff;
  wire [63:0] active_uid_ff, sysinfo_uid_ff;
  wire [31:0] bad_pw = stored_password ^ {lfsr_ff[31:1], 1'h1};
  integer     bad_count, check_count, i;
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  initial
  begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  secure_custom_command_handler #(.T_KILL_US(1), .T_PRIV_ON_US(1),
    .T_PRIV_OFF_US(1), .T_RAND_ON_US(1), .T_RAND_OFF_US(1)) i_dut (
    .sys_clk(sys_clk), .reset(reset), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_crc_ok(req_crc_ok), .req_option(req_option),
    .req_addressed(req_addressed), .req_uid(req_uid),
    .req_password(req_password),
    .selected_state(selected_state), .reader_eof(reader_eof),
    .stored_password(stored_password), .fixed_uid(fixed_uid),
    .nv_kill(nv_kill), .nv_privacy(nv_privacy), .nv_random(nv_random),
    .entropy_pin(entropy_pin), .rsp_valid_ff(rsp_valid_ff),
    .rsp_error_ff(rsp_error_ff), .rsp_code_ff(rsp_code_ff),
    .rsp_fast_read_ff(rsp_fast_read_ff), .nvm_wr_ff(nvm_wr_ff),
    .nvm_sel_ff(nvm_sel_ff), .nvm_val_ff(nvm_val_ff), .busy_ff(busy_ff),
    .dead_ff(dead_ff), .secure_ff(secure_ff), .privacy_ff(privacy_ff),
    .random_en_ff(random_en_ff), .active_uid_ff(active_uid_ff),
    .sysinfo_uid_ff(sysinfo_uid_ff));
  reader_model i_reader (.sys_clk(sys_clk), .opt_pend(opt_pend),
    .wait_cyc(wait_cyc), .eof_ff(reader_eof));
  task fail(input [8*24-1:0] msg);
  begin
    bad_count = bad_count + 1;
    $display("[FAIL] %0t %0s", $time, msg);
  end
  endtask
  task chk_bit(input got, input exp, input [8*24-1:0] msg);
  begin
    check_count = check_count + 1;
    if (got !== exp) fail(msg);
  end
  endtask
  task chk_rsp(input [1:0] exp);
  begin
    check_count = check_count + 1;
    if ({rsp_error_ff, rsp_fast_read_ff} !== exp ||
        (exp[1] && rsp_code_ff !== `ERR_NOT_ALLOWED)) fail("answer wrong");
  end
  endtask
  task chk_nvm(input [2:0] exp, input [7:0] cnt);
  begin
    check_count = check_count + 1;
    if (nvm_last !== exp || nvm_cnt !== cnt) fail("nvm write wrong");
  end
  endtask
  task chk_uid(input [63:0] got, input [63:0] exp, input [8*24-1:0] msg);
  begin
    check_count = check_count + 1;
    if (got !== exp) fail(msg);
  end
  endtask
  // Expected answer {error, fast}; 3 means no answer at all
  task send(input [7:0] c, input opt, input crc, input [31:0] pw,
            input [1:0] ex);
    integer n;
  begin
    req_cmd = c;
    req_option = opt;
    req_crc_ok = crc;
    req_password = pw;
    req_valid = 1'h1;
    opt_pend = opt;
    if (ex != 2'h3) exp_q.push_back(ex);
    @(posedge sys_clk);
    #1 req_valid = 1'h0;
    n = 0;
    while (ex != 2'h3 && rsp_valid_ff !== 1'h1 && n < 400)
    begin
      @(posedge sys_clk);
      #1 n = n + 1;
    end
    if (n == 400) fail("no answer");
    repeat (3) @(posedge sys_clk);
    #1 opt_pend = 1'h0;
  end
  endtask
  task final_report;
  begin
    if (exp_q.size() != 0) fail("answers missing");
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  always @(posedge sys_clk)
    if (rsp_valid_ff === 1'h1)
    begin
      if (exp_q.size() == 0) fail("unexpected answer");
      else chk_rsp(exp_q.pop_front());
    end
  always @(posedge sys_clk)
  begin
    lfsr_ff <= #1 lfsr(lfsr_ff);
    entropy_pin <= #1 lfsr_ff[0];
  end
  // Last NVM write request and number of requests seen
  always @(posedge sys_clk)
    if (nvm_wr_ff === 1'h1)
    begin
      nvm_cnt <= nvm_cnt + 8'h1;
      nvm_last <= {nvm_sel_ff, nvm_val_ff};
    end
  initial
  begin
    #40000;
    fail("timeout");
    final_report;
  end
  initial
  begin
    {bad_count, check_count} = 0;
    stored_password = lfsr(32'hd821);
    fixed_uid = {lfsr(32'h1234), lfsr(32'h5678)};
    {reset, req_crc_ok} = 2'h3;
    {req_valid, req_option, selected_state, nv_kill} = 4'h0;
    {req_addressed, nv_privacy, nv_random} = 3'h0;
    {opt_pend, req_cmd, req_password} = 41'h0;
    req_uid = 64'h0;
    wait_cyc = 10'h82;
    repeat (8) @(posedge sys_clk);
    #1 reset = 1'h0;
    repeat (2) @(posedge sys_clk);
    #1;
    send(`CMD_KILL, 1'h0, 1'h1, 32'h0, 2'h2);
    chk_bit(secure_ff, 1'h0, "secure at power-up");
    send(`CMD_LOGIN, 1'h0, 1'h1, bad_pw, 2'h2);
    send(`CMD_LOGIN, 1'h0, 1'h1, stored_password, 2'h0);
    chk_bit(secure_ff, 1'h1, "login failed");
    send(`CMD_LOGIN, 1'h0, 1'h1, bad_pw, 2'h2);
    chk_bit(secure_ff, 1'h1, "secure lost");
    send(`CMD_PRIV_ON, 1'h0, 1'h0, 32'h0, 2'h3);
    chk_bit(privacy_ff, 1'h0, "bad crc acted");
    send(`CMD_KILL, 1'h0, 1'h1, 32'h0, 2'h2);
    send(`CMD_RAND_ON, 1'h0, 1'h1, 32'h0, 2'h2);
    chk_bit(random_en_ff, 1'h0, "random on refused");
    chk_nvm(3'h0, 8'h0);
    $display("test refusals done");
    selected_state = 1'h1;
    // Codes ba, bb, be, bf; odd steps use the option flag
    for (i = 0; i < 4; i = i + 1)
    begin
      wait_cyc = 10'h82 + 10'h28 * i[9:0];
      send(8'hba + i[7:0] + (i[7:0] & 8'h2), i[0], 1'h1, 32'h0,
           2'h0);
      chk_bit(privacy_ff, i == 0, "privacy level");
      chk_bit(random_en_ff, i == 2, "random level");
      chk_nvm({(i < 2) ? `NVM_SEL_PRIV : `NVM_SEL_RAND, ~i[0]},
        i[7:0] + 8'h1);
      if (i == 2)
      begin
        first_uid = active_uid_ff;
        chk_uid(sysinfo_uid_ff, fixed_uid, "sysinfo in secure");
        // Fixed identifier no longer matches, presented one does
        req_addressed = 1'h1;
        req_uid = fixed_uid;
        send(`CMD_FAST_READ, 1'h0, 1'h1, 32'h0, 2'h3);
        req_uid = first_uid;
        send(`CMD_FAST_READ, 1'h0, 1'h1, 32'h0, 2'h1);
        req_addressed = 1'h0;
      end
      if (i == 3)
        chk_uid(active_uid_ff, fixed_uid, "fixed uid back");
    end
    send(`CMD_FAST_READ, 1'h0, 1'h1, 32'h0, 2'h1);
    $display("test writes done");
    wait_cyc = 10'hc8;
    send(`CMD_KILL, 1'h1, 1'h1, 32'h0, 2'h0);
    chk_bit(dead_ff, 1'h0, "dead before reset");
    chk_nvm({`NVM_SEL_KILL, 1'h1}, 8'h5);
    {nv_kill, nv_privacy, nv_random} = 3'h7;
    reset = 1'h1;
    repeat (2) @(posedge sys_clk);
    #1 reset = 1'h0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk_bit(dead_ff, 1'h1, "not dead");
    chk_bit(secure_ff, 1'h0, "secure after reset");
    chk_bit(privacy_ff, 1'h1, "privacy not restored");
    send(`CMD_LOGIN, 1'h0, 1'h1, stored_password, 2'h3);
    chk_uid(sysinfo_uid_ff, active_uid_ff, "sysinfo not random");
    chk_bit(active_uid_ff != first_uid, 1'h1, "uid not renewed");
    $display("test kill done");
    final_report;
  end
endmodule
